// ==== logic/anps_pkg.sv ====
package anps_pkg;

	// ==================================================
	// register map: index, byte address is index * 4
	// ==================================================
	localparam int ANPS_AW = 10;
	localparam logic [7:0] ANPS_LPBA_IDX = 8'h05;
	localparam logic [7:0] ANPS_EXP_IDX = 8'h06;
	localparam logic [7:0] ANPS_IRQ_STAT_IDX = 8'h10;
	localparam logic [7:0] ANPS_IRQ_MASK_IDX = 8'h11;
	localparam logic [7:0] ANPS_CTRL_IDX = 8'h12;

	// ==================================================
	// partner ability field positions
	// ==================================================
	localparam int ANPS_NP_BIT = 15;
	localparam int ANPS_ACK_BIT = 14;
	localparam int ANPS_RF_BIT = 13;
	localparam int ANPS_RSVD_BIT = 12;
	localparam int ANPS_ASYM_BIT = 11;
	localparam int ANPS_PAUSE_BIT = 10;
	localparam int ANPS_TECH_HI = 9;
	localparam int ANPS_TECH_LO = 5;
	localparam int ANPS_SEL_HI = 4;

	// ==================================================
	// expansion status field positions
	// ==================================================
	localparam int ANPS_PDF_BIT = 4;
	localparam int ANPS_LP_NP_BIT = 3;
	localparam int ANPS_LOC_NP_BIT = 2;
	localparam int ANPS_PAGE_BIT = 1;
	localparam int ANPS_LP_AN_BIT = 0;

	// ==================================================
	// control, interrupt layout and reset values
	// ==================================================
	localparam int ANPS_CTRL_NP_OVR_BIT = 0;
	localparam int ANPS_NEVT = 3;
	localparam int ANPS_EVT_PAGE = 0;
	localparam int ANPS_EVT_PDF = 1;
	localparam int ANPS_EVT_NP = 2;
	localparam logic [15:0] ANPS_LPBA_RST = 16'h0000;
	localparam logic [15:0] ANPS_RSVD_MASK = 16'hefff;
	localparam logic ANPS_LOC_NP_VAL = 1'b1;
	localparam logic ANPS_CTRL_RST = 1'b0;
	localparam logic [2:0] ANPS_IRQ_RST = 3'h0;

	// words from the negotiation state machine, same clock
	typedef struct packed {
		logic base_valid;
		logic [15:0] base_word;
		logic np_valid;
		logic [15:0] np_word;
		logic an_done;
		logic pd_fault;
	} anps_an_evt_t;

endpackage

// ==== logic/anps_page_latch.sv ====
`timescale 1ns/1ps
`default_nettype none
module anps_page_latch (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// page words
	input wire anps_pkg::anps_an_evt_t an_evt,
	input wire logic np_ovr_en,
	// captured state
	output logic [15:0] ability_r,
	output logic lp_next_page_r,
	output logic lp_autoneg_r,
	output logic np_take
);
	import anps_pkg::*;

	logic [15:0] ability_nxt;

	// next page may replace the base page only after a completed negotiation
	assign np_take = an_evt.np_valid & an_evt.an_done & np_ovr_en & lp_next_page_r & ~an_evt.base_valid;
	// bit n of the word lands in bit n; the reserved bit is forced low
	assign ability_nxt = an_evt.base_valid ? (an_evt.base_word & ANPS_RSVD_MASK) :
		np_take ? (an_evt.np_word & ANPS_RSVD_MASK) : ability_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ability_r <= ANPS_LPBA_RST;
			lp_next_page_r <= 1'b0;
			lp_autoneg_r <= 1'b0;
		end else begin
			ability_r <= ability_nxt;
			if (an_evt.base_valid) begin
				lp_next_page_r <= an_evt.base_word[ANPS_NP_BIT];
				lp_autoneg_r <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// ==== logic/anps_irq_bank.sv ====
`timescale 1ns/1ps
`default_nettype none
module anps_irq_bank (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// events and software access
	input wire logic [anps_pkg::ANPS_NEVT-1:0] evt,
	input wire logic [anps_pkg::ANPS_NEVT-1:0] w1c,
	input wire logic mask_we,
	input wire logic [anps_pkg::ANPS_NEVT-1:0] mask_wdata,
	// state
	output logic [anps_pkg::ANPS_NEVT-1:0] status_r,
	output logic [anps_pkg::ANPS_NEVT-1:0] mask_r,
	output logic irq_r
);
	import anps_pkg::*;

	logic [ANPS_NEVT-1:0] status_nxt;

	genvar i;
	generate
		for (i = 0; i < ANPS_NEVT; i++) begin : g_bit
			// a new event wins over a clear in the same cycle
			assign status_nxt[i] = evt[i] | (status_r[i] & ~w1c[i]);
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_r <= ANPS_IRQ_RST;
			mask_r <= ANPS_IRQ_RST;
			irq_r <= 1'b0;
		end else begin
			status_r <= status_nxt;
			if (mask_we) begin
				mask_r <= mask_wdata;
			end
			irq_r <= |(status_nxt & (mask_we ? mask_wdata : mask_r));
		end
	end
endmodule
`default_nettype wire

// ==== logic/anps_status_regs.sv ====
// Function
// - read-only register holds abilities from the partner's received base page
// - after completed negotiation a next page may overwrite the partner abilities
// - bit 15 shows the partner's next page request, resets to zero
// - bit 14 shows partner acknowledge, taken from incoming link pulse bursts
// - bit 13 shows partner remote fault
// - bit 12 is reserved and always reads zero
// - bit 11 shows partner asymmetric pause support
// - bit 10 shows partner symmetric pause support
// - bits 9 to 5 show partner technology abilities, one when supported
// - bits 4 to 0 hold partner protocol selector, reset zero
// - expansion bits 15 to 5 ignore writes and read zero
// - expansion bit 4 shows a parallel detection fault, resets zero
// - expansion bit 3 shows partner next page ability
// - expansion bit 2 is constant one, local next page ability
// - expansion bit 1 sets on page received, cleared by reading
// - expansion bit 0 shows partner auto-negotiation ability
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module anps_status_regs (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [anps_pkg::ANPS_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// negotiation state machine
	input wire anps_pkg::anps_an_evt_t an_evt,
	// interrupt
	output logic irq
);
	import anps_pkg::*;

	// ==================================================
	// bus decode
	// ==================================================
	logic [7:0] idx;
	logic aligned;
	logic setup_ph;
	logic done;
	logic wr_done;
	logic rd_done;
	logic hit_lpba;
	logic hit_exp;
	logic hit_stat;
	logic hit_mask;
	logic hit_ctrl;
	logic mapped;

	assign idx = paddr[ANPS_AW-1:2];
	assign aligned = (paddr[1:0] == 2'h0);
	assign setup_ph = psel & ~penable;
	assign done = psel & penable & pready;
	assign wr_done = done & pwrite;
	assign rd_done = done & ~pwrite;
	assign hit_lpba = aligned & (idx == ANPS_LPBA_IDX);
	assign hit_exp = aligned & (idx == ANPS_EXP_IDX);
	assign hit_stat = aligned & (idx == ANPS_IRQ_STAT_IDX);
	assign hit_mask = aligned & (idx == ANPS_IRQ_MASK_IDX);
	assign hit_ctrl = aligned & (idx == ANPS_CTRL_IDX);
	assign mapped = hit_lpba | hit_exp | hit_stat | hit_mask | hit_ctrl;

	// ==================================================
	// partner page capture
	// ==================================================
	logic [15:0] ability_r;
	logic lp_next_page_r;
	logic lp_autoneg_r;
	logic np_take;
	logic np_ovr_r;

	anps_page_latch u_latch (
		.pclk(pclk),
		.presetn(presetn),
		.an_evt(an_evt),
		.np_ovr_en(np_ovr_r),
		.ability_r(ability_r),
		.lp_next_page_r(lp_next_page_r),
		.lp_autoneg_r(lp_autoneg_r),
		.np_take(np_take)
	);

	// ==================================================
	// expansion status
	// ==================================================
	logic page_rx_r;
	logic page_rx_nxt;
	logic page_set;
	logic page_clr;
	logic pd_fault_r;
	logic [15:0] exp_word;

	// a page accepted also raises the flag, which reads high from the next cycle
	assign page_set = an_evt.base_valid | np_take;
	// only a flag value the reader actually saw is cleared
	assign page_clr = rd_done & hit_exp & prdata[ANPS_PAGE_BIT];
	assign page_rx_nxt = page_set | (page_rx_r & ~page_clr);

	always_comb begin
		exp_word = 16'h0000;
		exp_word[ANPS_PDF_BIT] = pd_fault_r;
		exp_word[ANPS_LP_NP_BIT] = lp_next_page_r;
		exp_word[ANPS_LOC_NP_BIT] = ANPS_LOC_NP_VAL;
		exp_word[ANPS_PAGE_BIT] = page_rx_r;
		exp_word[ANPS_LP_AN_BIT] = lp_autoneg_r;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			page_rx_r <= 1'b0;
			pd_fault_r <= 1'b0;
		end else begin
			page_rx_r <= page_rx_nxt;
			pd_fault_r <= an_evt.pd_fault;
		end
	end

	// ==================================================
	// interrupts and control
	// ==================================================
	logic [ANPS_NEVT-1:0] evt;
	logic [ANPS_NEVT-1:0] w1c;
	logic [ANPS_NEVT-1:0] irq_stat;
	logic [ANPS_NEVT-1:0] irq_mask;
	logic irq_r;

	assign evt[ANPS_EVT_PAGE] = page_set;
	assign evt[ANPS_EVT_PDF] = an_evt.pd_fault & ~pd_fault_r;
	assign evt[ANPS_EVT_NP] = np_take;
	assign w1c = (wr_done & hit_stat) ? pwdata[ANPS_NEVT-1:0] : {ANPS_NEVT{1'b0}};

	anps_irq_bank u_irq (
		.pclk(pclk),
		.presetn(presetn),
		.evt(evt),
		.w1c(w1c),
		.mask_we(wr_done & hit_mask),
		.mask_wdata(pwdata[ANPS_NEVT-1:0]),
		.status_r(irq_stat),
		.mask_r(irq_mask),
		.irq_r(irq_r)
	);
	assign irq = irq_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			np_ovr_r <= ANPS_CTRL_RST;
		end else if (wr_done & hit_ctrl) begin
			np_ovr_r <= pwdata[ANPS_CTRL_NP_OVR_BIT];
		end
	end

	// ==================================================
	// read mux and bus answer
	// ==================================================
	logic [31:0] rd_mux;
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;

	assign rd_mux = hit_lpba ? {16'h0000, ability_r} :
		hit_exp ? {16'h0000, exp_word} :
		hit_stat ? {{(32-ANPS_NEVT){1'b0}}, irq_stat} :
		hit_mask ? {{(32-ANPS_NEVT){1'b0}}, irq_mask} :
		hit_ctrl ? {31'h00000000, np_ovr_r} : 32'h00000000;

	// answer is prepared in the setup cycle so every access waits none
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h00000000;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			pready_r <= setup_ph;
			if (setup_ph) begin
				prdata_r <= pwrite ? 32'h00000000 : rd_mux;
				pslverr_r <= ~mapped;
			end
		end
	end
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;

	// ==================================================
	// checks
	// ==================================================
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// a read answer carries what was latched in the setup cycle
	logic lpba_rd_ans;
	logic exp_rd_ans;
	assign lpba_rd_ans = psel & penable & pready & ~pwrite & hit_lpba;
	assign exp_rd_ans = psel & penable & pready & ~pwrite & hit_exp;

	a_base_capture: assert property (
		an_evt.base_valid |=> ability_r == ($past(an_evt.base_word) & ANPS_RSVD_MASK))
		else $error("base page not captured");

	a_np_overwrite: assert property (
		an_evt.np_valid && an_evt.an_done && np_ovr_r && lp_next_page_r && !an_evt.base_valid
		|=> ability_r == ($past(an_evt.np_word) & ANPS_RSVD_MASK))
		else $error("next page did not overwrite abilities");

	a_np_blocked: assert property (
		!an_evt.base_valid && (!an_evt.an_done || !np_ovr_r) |=> $stable(ability_r))
		else $error("abilities changed without a permitted page");

	a_np_field: assert property (
		lpba_rd_ans |-> prdata[ANPS_NP_BIT] == $past(ability_r[ANPS_NP_BIT]))
		else $error("next page request bit not reported");

	a_lpba_read: assert property (
		lpba_rd_ans |-> prdata[15:0] == $past(ability_r))
		else $error("partner ability read does not match capture");

	a_rsvd_store: assert property (
		ability_r[ANPS_RSVD_BIT] == 1'b0)
		else $error("reserved partner bit stored nonzero");

	a_sel_field: assert property (
		an_evt.base_valid |=> ability_r[ANPS_SEL_HI:0] == $past(an_evt.base_word[ANPS_SEL_HI:0]))
		else $error("protocol selector mismatch");

	a_pause_fields: assert property (
		an_evt.base_valid |=> ability_r[ANPS_ASYM_BIT] == $past(an_evt.base_word[ANPS_ASYM_BIT]) &&
		ability_r[ANPS_PAUSE_BIT] == $past(an_evt.base_word[ANPS_PAUSE_BIT]))
		else $error("pause ability bits mismatch");

	a_ack_field: assert property (
		an_evt.base_valid |=> ability_r[ANPS_ACK_BIT] == $past(an_evt.base_word[ANPS_ACK_BIT]))
		else $error("acknowledge bit mismatch");

	a_fault_pause: assert property (
		an_evt.base_valid |=> ability_r[ANPS_RF_BIT:ANPS_PAUSE_BIT] ==
		($past(an_evt.base_word[ANPS_RF_BIT:ANPS_PAUSE_BIT]) & 4'hb))
		else $error("fault or pause bits mismatch");

	a_rsvd_zero: assert property (
		lpba_rd_ans |-> prdata[ANPS_RSVD_BIT] == 1'b0 && prdata[31:16] == 16'h0000)
		else $error("reserved partner bit read nonzero");

	a_tech_sel: assert property (
		an_evt.base_valid |=> ability_r[ANPS_TECH_HI:0] == $past(an_evt.base_word[ANPS_TECH_HI:0]))
		else $error("technology or selector field mismatch");

	a_exp_rsvd: assert property (
		exp_rd_ans |-> prdata[31:5] == 27'h0000000 && prdata[ANPS_LOC_NP_BIT])
		else $error("expansion reserved bits or constant wrong");

	a_pdf_report: assert property (
		exp_rd_ans |-> prdata[ANPS_PDF_BIT] == $past(pd_fault_r))
		else $error("parallel detect fault not reported");

	a_lp_next_page: assert property (
		an_evt.base_valid |=> lp_next_page_r == $past(an_evt.base_word[ANPS_NP_BIT]))
		else $error("partner next page ability wrong");

	// ==================================================
	// expansion, ready and interrupt checks
	// ==================================================

	a_exp_fields: assert property (
		exp_rd_ans |-> prdata[ANPS_LP_NP_BIT] == $past(lp_next_page_r) &&
		prdata[ANPS_LP_AN_BIT] == $past(lp_autoneg_r))
		else $error("partner ability flags not reported");

	a_page_report: assert property (
		exp_rd_ans |-> prdata[ANPS_PAGE_BIT] == $past(page_rx_r))
		else $error("page flag not reported");

	a_np_page_set: assert property (
		np_take |=> page_rx_r && irq_stat[ANPS_EVT_NP])
		else $error("next page take did not raise the flags");

	a_pdf_event: assert property (
		an_evt.pd_fault && !pd_fault_r |=> irq_stat[ANPS_EVT_PDF] && pd_fault_r)
		else $error("parallel detect fault event lost");

	a_page_set_wins: assert property (
		page_set && page_clr |=> page_rx_r)
		else $error("clear by read beat a new page");

	a_page_set: assert property (
		an_evt.base_valid |=> page_rx_r && irq_stat[ANPS_EVT_PAGE])
		else $error("page flag not set with the capture");

	a_page_cor: assert property (
		exp_rd_ans && prdata[ANPS_PAGE_BIT] && !page_set |=> !page_rx_r)
		else $error("page flag not cleared by read");

	a_page_hold: assert property (
		page_rx_r && !exp_rd_ans |=> page_rx_r)
		else $error("page flag lost without a read");

	a_an_able: assert property (
		an_evt.base_valid |=> lp_autoneg_r ##1 lp_autoneg_r)
		else $error("partner autoneg ability not held");

	a_ready_once: assert property (
		psel && !penable |=> pready ##1 !pready)
		else $error("ready not a single access cycle");

	a_irq_follow: assert property (
		(irq_stat[ANPS_EVT_PAGE] && irq_mask[ANPS_EVT_PAGE]) [*2] |-> irq)
		else $error("unmasked event does not raise irq");

	// ==================================================
	// bus and interrupt checks
	// ==================================================

	a_irq_quiet: assert property (
		(irq_stat & irq_mask) == {ANPS_NEVT{1'b0}} && evt == {ANPS_NEVT{1'b0}} && !(wr_done && hit_mask)
		|=> !irq)
		else $error("irq raised with nothing unmasked pending");

	a_err_unmapped: assert property (
		psel && penable && pready |-> pslverr == !mapped)
		else $error("error answer does not match the decode");

	a_wr_rdata: assert property (
		psel && penable && pready && pwrite |-> prdata == 32'h00000000)
		else $error("read data not zero on a write");

	a_ready_setup: assert property (
		!psel |=> !pready)
		else $error("ready without a selected transfer");

	c_base_page: cover property (an_evt.base_valid ##[1:50] exp_rd_ans && prdata[ANPS_PAGE_BIT]);
	c_np_over: cover property (np_take);
	c_cor_clear: cover property (page_clr ##1 !page_rx_r);
	c_irq_rise: cover property (!irq ##1 irq);
	c_pdf_rise: cover property (evt[ANPS_EVT_PDF]);
endmodule
`default_nettype wire

// ==== dv/anps_lp_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module anps_lp_model (
	// clock
	input wire logic pclk,
	// words toward the status block
	output var anps_pkg::anps_an_evt_t an_evt
);
	import anps_pkg::*;
	initial begin
		an_evt = '0;
	end
	// ==============================
	// one accepted word per pulse; the word turns over once released
	task automatic send(input logic np, input logic [15:0] w);
		@(posedge pclk);
		an_evt.base_valid <= !np;
		an_evt.np_valid <= np;
		an_evt.base_word <= w;
		an_evt.np_word <= w;
		@(posedge pclk);
		an_evt.base_valid <= 1'b0;
		an_evt.np_valid <= 1'b0;
		an_evt.base_word <= ~w;
		an_evt.np_word <= ~w;
	endtask
	task automatic set_lvl(input logic done, input logic parallel_detect_fault);
		@(posedge pclk);
		an_evt.an_done <= done;
		an_evt.pd_fault <= parallel_detect_fault;
		@(posedge pclk);
	endtask
endmodule
`default_nettype wire

// ==== dv/anps_status_regs_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module anps_status_regs_bench;
	import anps_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
	logic [9:0] paddr;
	logic [31:0] pwdata, prdata;
	anps_an_evt_t an_evt;
	int n_fail = 0;
	int checks_done = 0;
	localparam logic [9:0] A_LP = {ANPS_LPBA_IDX, 2'b00};
	localparam logic [9:0] A_EX = {ANPS_EXP_IDX, 2'b00};
	localparam logic [9:0] A_ST = {ANPS_IRQ_STAT_IDX, 2'b00};
	localparam logic [9:0] A_MK = {ANPS_IRQ_MASK_IDX, 2'b00};
	localparam logic [9:0] A_CT = {ANPS_CTRL_IDX, 2'b00};
	anps_status_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .an_evt(an_evt),
		.irq(irq));
	anps_lp_model lp_u (.pclk(pclk), .an_evt(an_evt));
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	// ==============================
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// apb transfer: hold until pready seen high at a rising edge
	task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] wd, output logic [31:0] rd,
		output logic err);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		// only the watchdog ends a wait that never sees ready
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [9:0] a, input logic [31:0] e, input logic ee = 1'b0);
		logic [31:0] d;
		logic r;
		apb(1'b0, a, 32'h0, d, r);
		chk("read data", e, d);
		chk("read error", {31'h0, ee}, {31'h0, r});
	endtask
	task automatic wr(input logic [9:0] a, input logic [31:0] v);
		logic [31:0] d;
		logic r;
		apb(1'b1, a, v, d, r);
		chk("write error", 32'h0, {31'h0, r});
	endtask
	task automatic chk_irq(input logic e);
		@(posedge pclk);
		#1;
		chk("irq", {31'h0, e}, {31'h0, irq});
	endtask
	// ==============================
	task automatic t_reset();
		rd(A_LP, 32'h0);
		rd(A_EX, 32'h4);
		rd(10'h3c, 32'h0, 1'b1);
		rd(A_ST, 32'h0);
		rd(A_MK, 32'h0);
		rd(A_CT, 32'h0);
	endtask
	task automatic t_pdf();
		lp_u.set_lvl(1'b0, 1'b1);
		rd(A_EX, 32'h14);
		rd(A_ST, 32'h2);
		lp_u.set_lvl(1'b0, 1'b0);
		rd(A_EX, 32'h4);
	endtask
	task automatic t_walk();
		logic [15:0] w;
		logic [31:0] x;
		for (int i = 0; i < 16; i++) begin
			w = 16'h1 << i;
			x = (i == 15) ? 32'hd : 32'h5;
			lp_u.send(1'b0, w);
			rd(A_LP, {16'h0, w & 16'hefff});
			rd(A_EX, x | 32'h2);
			rd(A_EX, x);
		end
	endtask
	task automatic t_ro();
		wr(A_LP, 32'hffffffff);
		wr(A_EX, 32'hffffffff);
		rd(A_LP, 32'h8000);
		rd(A_EX, 32'hd);
	endtask
	task automatic t_irq();
		wr(A_ST, 32'h7);
		rd(A_ST, 32'h0);
		lp_u.send(1'b0, 16'h0021);
		chk_irq(1'b0);
		wr(A_MK, 32'h1);
		chk_irq(1'b1);
		wr(A_ST, 32'h1);
		chk_irq(1'b0);
		rd(A_ST, 32'h0);
		rd(A_LP, 32'h21);
	endtask
	task automatic t_np();
		lp_u.send(1'b0, 16'h8001);
		lp_u.send(1'b1, 16'h5a5a);
		rd(A_LP, 32'h8001);
		wr(A_CT, 32'h1);
		rd(A_CT, 32'h1);
		lp_u.set_lvl(1'b1, 1'b0);
		lp_u.send(1'b1, 16'h5a5a);
		rd(A_LP, 32'h4a5a);
		rd(A_EX, 32'hf);
		rd(A_ST, 32'h5);
		chk_irq(1'b1);
		lp_u.send(1'b1, 16'h8123);
		rd(A_EX, 32'hf);
		rd(A_LP, 32'h8123);
	endtask
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 10'h0;
		pwdata = 32'h0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_pdf();
		t_walk();
		t_ro();
		t_irq();
		t_np();
		finish_test();
	end
	initial begin
		#(20000 * 40);
		n_fail++;
		finish_test();
	end
endmodule
`default_nettype wire
